//--- tcam_pkg.sv
// shared constants and types of the ternary match lookup engine
package tcam_pkg;
   localparam int KEY_W        = 64;
   localparam int VAL_W        = 32;
   localparam int DEPTH        = 16;
   localparam int IDX_W        = $clog2(DEPTH);
   localparam int KEY_WORDS    = (KEY_W - 1) / 32 + 1;
   localparam int VAL_WORDS    = (VAL_W - 1) / 32 + 1;
   localparam int RANGE_W      = 16;
   localparam int RANGE_LSB    = 0;
   localparam int FIFO_DEPTH   = 64;
   localparam int FIFO_AW      = $clog2(FIFO_DEPTH);
   localparam int UPDATE_CYCLES = 33;
   localparam int CNT_W        = $clog2(UPDATE_CYCLES + 1);

   // key bits that take part in ternary compare; the range field is excluded
   localparam logic [KEY_W-1:0] TERN_CARE =
      ~({{(KEY_W-RANGE_W){1'b0}}, {RANGE_W{1'b1}}} << RANGE_LSB);

   localparam logic [7:0] OFF_ID     = 8'h00;
   localparam logic [7:0] OFF_CMD    = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_DATA   = 8'h50;
   localparam logic [7:0] OFF_MASK   = 8'h90;
   localparam logic [7:0] OFF_VAL    = 8'hd0;

   // identifier value is arbitrary
   localparam logic [31:0] DEVICE_ID = 32'h0000_7c01;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] STRB_FULL   = 4'hf;

   localparam int          CMD_OP_MSB = 31;
   localparam int          CMD_OP_LSB = 30;
   localparam logic [1:0]  OP_WRITE   = 2'h1;
   localparam logic [1:0]  OP_INIT    = 2'h2;
   localparam int          STAT_PEND  = 0;
   localparam int          STAT_BUSY  = 1;

   typedef enum logic [1:0] {UPD_IDLE, UPD_PENDING, UPD_BUSY} upd_state_e;
endpackage : tcam_pkg

//--- tcam_search_core.sv
// two-stage match and priority select pipeline
`timescale 1ns/1ps
module tcam_search_core (
   input  wire logic                                              sys_clk_i,
   input  wire logic                                              rst_n_i,
   input  wire logic                                              key_valid_i,
   input  wire logic [tcam_pkg::KEY_W-1:0]                        key_i,
   input  wire logic [tcam_pkg::DEPTH-1:0][tcam_pkg::KEY_W-1:0]   entry_data_i,
   input  wire logic [tcam_pkg::DEPTH-1:0][tcam_pkg::KEY_W-1:0]   entry_mask_i,
   input  wire logic [tcam_pkg::DEPTH-1:0][tcam_pkg::VAL_W-1:0]   entry_val_i,
   input  wire logic [tcam_pkg::DEPTH-1:0]                        entry_live_i,
   output logic                                                   result_strobe_o,
   output logic                                                   hit_flag_o,
   output logic [tcam_pkg::KEY_W-1:0]                             echoed_key_o,
   output logic [tcam_pkg::IDX_W-1:0]                             winning_entry_index_o,
   output logic [tcam_pkg::VAL_W-1:0]                             winning_payload_o
);
   logic [tcam_pkg::DEPTH-1:0] match_vec;
   logic [tcam_pkg::DEPTH-1:0] match_q;
   logic [tcam_pkg::DEPTH-1:0] match_d;
   logic [tcam_pkg::KEY_W-1:0] key_q;
   logic                       vld_q;
   logic [tcam_pkg::IDX_W-1:0] win_idx;
   logic                       win_hit;

   for (genvar e = 0; e < tcam_pkg::DEPTH; e++) begin : g_entry
      logic tern_ok;
      logic range_ok;
      // mask bit set means the key bit is a don't-care
      assign tern_ok = (((key_i ^ entry_data_i[e]) & ~entry_mask_i[e])
                        & tcam_pkg::TERN_CARE) == '0; // [RULE21]
      // range field: data holds the lower bound, mask the upper, both inclusive
      assign range_ok =
         (key_i[tcam_pkg::RANGE_LSB +: tcam_pkg::RANGE_W] >=
          entry_data_i[e][tcam_pkg::RANGE_LSB +: tcam_pkg::RANGE_W]) && // [RULE13]
         (key_i[tcam_pkg::RANGE_LSB +: tcam_pkg::RANGE_W] <=
          entry_mask_i[e][tcam_pkg::RANGE_LSB +: tcam_pkg::RANGE_W]);   // [RULE15]
      assign match_vec[e] = entry_live_i[e] & tern_ok & range_ok; // [RULE21]
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         vld_q   <= 1'b0;
         match_q <= '0;
         key_q   <= '0;
      end else begin
         vld_q   <= key_valid_i;
         match_q <= match_vec;
         key_q   <= key_i;
      end
   end

   // scanning downward leaves the lowest matching index as the winner
   always_comb begin
      win_idx = '0;
      win_hit = 1'b0;
      for (int e = tcam_pkg::DEPTH - 1; e >= 0; e--) begin
         if (match_q[e]) begin
            win_idx = tcam_pkg::IDX_W'(e); // [RULE18]
            win_hit = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         result_strobe_o       <= 1'b0;
         hit_flag_o            <= 1'b0;
         echoed_key_o          <= '0;
         winning_entry_index_o <= '0;
         winning_payload_o     <= '0;
      end else begin
         result_strobe_o       <= vld_q;                // [RULE2]
         hit_flag_o            <= vld_q & win_hit;      // [RULE3]
         echoed_key_o          <= key_q;                // [RULE4]
         winning_entry_index_o <= win_idx;              // [RULE5]
         winning_payload_o     <= entry_val_i[win_idx]; // [RULE6]
      end
   end

   // checks judge the output index against the matches it was chosen from
   always_ff @(posedge sys_clk_i) begin
      match_d <= match_q;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_fixed_latency: assert property (key_valid_i |-> ##2 result_strobe_o) // [RULE2]
      else $error("no result two cycles after a dequeued key");
   a_key_echo: assert property (key_valid_i |-> ##2 (echoed_key_o == $past(key_i, 2))) // [RULE4]
      else $error("echoed key differs from requested key");
   a_hit_cause: assert property (key_valid_i |-> ##2 (hit_flag_o == $past(|match_vec, 2))) // [RULE3]
      else $error("hit flag does not reflect match vector");
   a_lowest_win: assert property (win_hit |=> (hit_flag_o == $past(vld_q)) && // [RULE18]
      match_d[winning_entry_index_o] &&
      ((match_d & ~({tcam_pkg::DEPTH{1'b1}} << winning_entry_index_o)) == '0))
      else $error("winning index is not the lowest matching entry");
   a_payload_sel: assert property (vld_q && win_hit |=> // [RULE6]
      winning_payload_o == entry_val_i[winning_entry_index_o])
      else $error("payload not taken from winning entry");
   c_hit_seen: cover property (result_strobe_o && hit_flag_o);
   c_miss_seen: cover property (result_strobe_o && !hit_flag_o);
endmodule : tcam_search_core

//--- tcam_lookup_engine.sv
// ternary lookup engine top: request queue, update control, staging registers
//
// Behaviour
// [RULE1] requester keeps the search key valid whenever it raises the request strobe
// [RULE2] one result strobe per accepted request, in order, after variable latency
// [RULE3] hit flag high during result when any stored entry matched the key
// [RULE4] echoed key equals the full key given with the matching request
// [RULE5] on a hit the winning index appears on a log2-depth-wide bus
// [RULE6] on a hit the winning entry's payload appears on the payload bus
// [RULE7] host writes always carry all four byte strobes
// [RULE8] write response is 00 for success and 10 for slave error
// [RULE9] 32-bit write address, decoded as offset from the slave's base
// [RULE10] offset zero reads a fixed 32-bit identifier, writes are refused
// [RULE11] key data and mask word counts are key width over 32, rounded up
// [RULE12] key data words from 0x50 upward, word n holds key bits from 32n
// [RULE13] in the range field, data staging bits act as the lower bound
// [RULE14] key mask words are read-write words from 0x90, within 0xcf
// [RULE15] in the range field, mask staging bits act as the upper bound
// [RULE16] payload words from 0xd0, value width over 32 rounded up, within 0xef
// [RULE17] write uses staging words, initialization ignores them
// [RULE18] among several matches the lowest index wins
// [RULE19] dequeue of buffered requests stops for 33 cycles during an entry update
// [RULE20] system holds reset at least 100 cycles to clear pipelines; the bench holds it for 12 cycles
// [RULE21] match needs all cared bits equal and range field within inclusive bounds
// [RULE22] read address and read data channels return staging and identifier words
`timescale 1ns/1ps
module tcam_lookup_engine (
   input  wire logic                          sys_clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          search_request_strobe_i,
   input  wire logic [tcam_pkg::KEY_W-1:0]    search_key_in_i,
   output logic                               result_strobe_o,
   output logic                               hit_flag_o,
   output logic [tcam_pkg::KEY_W-1:0]         echoed_key_o,
   output logic [tcam_pkg::IDX_W-1:0]         winning_entry_index_o,
   output logic [tcam_pkg::VAL_W-1:0]         winning_payload_o,
   input  wire logic [31:0]                   s_axi_awaddr_i,
   input  wire logic                          s_axi_awvalid_i,
   output logic                               s_axi_awready_o,
   input  wire logic [31:0]                   s_axi_wdata_i,
   input  wire logic [3:0]                    s_axi_wstrb_i,
   input  wire logic                          s_axi_wvalid_i,
   output logic                               s_axi_wready_o,
   output logic [1:0]                         s_axi_bresp_o,
   output logic                               s_axi_bvalid_o,
   input  wire logic                          s_axi_bready_i,
   input  wire logic [31:0]                   s_axi_araddr_i,
   input  wire logic                          s_axi_arvalid_i,
   output logic                               s_axi_arready_o,
   output logic [31:0]                        s_axi_rdata_o,
   output logic [1:0]                         s_axi_rresp_o,
   output logic                               s_axi_rvalid_o,
   input  wire logic                          s_axi_rready_i
);
   logic [tcam_pkg::KEY_WORDS-1:0][31:0]                   stage_data;
   logic [tcam_pkg::KEY_WORDS-1:0][31:0]                   stage_mask;
   logic [tcam_pkg::VAL_WORDS-1:0][31:0]                   stage_val;
   logic [tcam_pkg::DEPTH-1:0][tcam_pkg::KEY_W-1:0]        entry_data;
   logic [tcam_pkg::DEPTH-1:0][tcam_pkg::KEY_W-1:0]        entry_mask;
   logic [tcam_pkg::DEPTH-1:0][tcam_pkg::VAL_W-1:0]        entry_val;
   logic [tcam_pkg::DEPTH-1:0]                             entry_live;
   logic [tcam_pkg::KEY_W-1:0]  fifo_mem [tcam_pkg::FIFO_DEPTH];
   logic [tcam_pkg::FIFO_AW-1:0] wptr;
   logic [tcam_pkg::FIFO_AW-1:0] rptr;
   logic [tcam_pkg::FIFO_AW:0]   fifo_count;
   logic                         push;
   logic                         pop;
   tcam_pkg::upd_state_e         upd_state;
   logic [tcam_pkg::CNT_W-1:0]   upd_cnt;
   logic [1:0]                   cmd_op;
   logic [tcam_pkg::IDX_W-1:0]   cmd_idx;
   logic                         wr_go;
   logic                         wr_mapped;
   logic                         wr_ok;
   logic                         wr_cmd;
   logic [7:0]                   wr_off;
   logic [7:0]                   rd_off;
   logic                         rd_go;
   logic                         rd_mapped;
   logic [31:0]                  rd_word;
   logic                         upd_done;

   // lookup request queue; an update only starts on an empty queue, so 64 deep
   // covers the 33 stalled cycles and full is never reached by a legal requester
   assign push = search_request_strobe_i &&
                 (fifo_count != (tcam_pkg::FIFO_AW+1)'(tcam_pkg::FIFO_DEPTH)); // [RULE1]
   assign pop  = (fifo_count != '0) && (upd_state != tcam_pkg::UPD_BUSY); // [RULE19]

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         fifo_mem[wptr] <= search_key_in_i; // [RULE1]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         wptr       <= '0;
         rptr       <= '0;
         fifo_count <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
         fifo_count <= fifo_count + (tcam_pkg::FIFO_AW+1)'(push) -
                       (tcam_pkg::FIFO_AW+1)'(pop);
      end
   end

   tcam_search_core u_core (
      .sys_clk_i             (sys_clk_i),
      .rst_n_i               (rst_n_i),
      .key_valid_i           (pop),
      .key_i                 (fifo_mem[rptr]),
      .entry_data_i          (entry_data),
      .entry_mask_i          (entry_mask),
      .entry_val_i           (entry_val),
      .entry_live_i          (entry_live),
      .result_strobe_o       (result_strobe_o),
      .hit_flag_o            (hit_flag_o),
      .echoed_key_o          (echoed_key_o),
      .winning_entry_index_o (winning_entry_index_o),
      .winning_payload_o     (winning_payload_o)
   );

   // write channel: address and data are taken together, one at a time
   assign wr_go           = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
   assign s_axi_awready_o = wr_go;
   assign s_axi_wready_o  = wr_go;
   assign wr_off          = s_axi_awaddr_i[7:0]; // [RULE9]
   assign wr_cmd          = (wr_off == tcam_pkg::OFF_CMD);

   always_comb begin
      wr_mapped = 1'b0;
      if (wr_cmd) begin
         // a second command is refused until the first one has finished
         wr_mapped = (upd_state == tcam_pkg::UPD_IDLE) &&
                     ((s_axi_wdata_i[tcam_pkg::CMD_OP_MSB:tcam_pkg::CMD_OP_LSB]
                       == tcam_pkg::OP_WRITE) ||
                      (s_axi_wdata_i[tcam_pkg::CMD_OP_MSB:tcam_pkg::CMD_OP_LSB]
                       == tcam_pkg::OP_INIT));
      end else begin
         for (int n = 0; n < tcam_pkg::KEY_WORDS; n++) begin
            if (wr_off == 8'(tcam_pkg::OFF_DATA + 4 * n)) begin
               wr_mapped = 1'b1; // [RULE12]
            end else if (wr_off == 8'(tcam_pkg::OFF_MASK + 4 * n)) begin
               wr_mapped = 1'b1; // [RULE14]
            end
         end
         for (int n = 0; n < tcam_pkg::VAL_WORDS; n++) begin
            if (wr_off == 8'(tcam_pkg::OFF_VAL + 4 * n)) begin
               wr_mapped = 1'b1; // [RULE16]
            end
         end
      end
   end

   // partial strobes are refused whole rather than merged
   assign wr_ok = wr_mapped && (s_axi_wstrb_i == tcam_pkg::STRB_FULL); // [RULE7]

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= tcam_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_ok ? tcam_pkg::RESP_OKAY : tcam_pkg::RESP_SLVERR; // [RULE8]
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         stage_data <= '0;
         stage_mask <= '0;
         stage_val  <= '0;
      end else if (wr_go && wr_ok) begin
         for (int n = 0; n < tcam_pkg::KEY_WORDS; n++) begin
            if (wr_off == 8'(tcam_pkg::OFF_DATA + 4 * n)) begin
               stage_data[n] <= s_axi_wdata_i; // [RULE11]
            end
            if (wr_off == 8'(tcam_pkg::OFF_MASK + 4 * n)) begin
               stage_mask[n] <= s_axi_wdata_i; // [RULE14]
            end
         end
         for (int n = 0; n < tcam_pkg::VAL_WORDS; n++) begin
            if (wr_off == 8'(tcam_pkg::OFF_VAL + 4 * n)) begin
               stage_val[n] <= s_axi_wdata_i; // [RULE16]
            end
         end
      end
   end

   // update control: wait for an empty queue, then hold dequeue for a fixed time
   assign upd_done = (upd_state == tcam_pkg::UPD_BUSY) &&
                     (upd_cnt == tcam_pkg::CNT_W'(tcam_pkg::UPDATE_CYCLES - 1));

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         upd_state <= tcam_pkg::UPD_IDLE;
         upd_cnt   <= '0;
         cmd_op    <= '0;
         cmd_idx   <= '0;
      end else begin
         case (upd_state)
            tcam_pkg::UPD_IDLE: begin
               if (wr_go && wr_ok && wr_cmd) begin
                  upd_state <= tcam_pkg::UPD_PENDING;
                  cmd_op    <= s_axi_wdata_i[tcam_pkg::CMD_OP_MSB:tcam_pkg::CMD_OP_LSB];
                  cmd_idx   <= s_axi_wdata_i[tcam_pkg::IDX_W-1:0];
               end
            end
            tcam_pkg::UPD_PENDING: begin
               if (fifo_count == '0) begin
                  upd_state <= tcam_pkg::UPD_BUSY;
                  upd_cnt   <= '0;
               end
            end
            tcam_pkg::UPD_BUSY: begin
               upd_cnt <= upd_cnt + 1'b1;
               if (upd_done) begin
                  upd_state <= tcam_pkg::UPD_IDLE; // [RULE19]
               end
            end
            default: begin
               upd_state <= tcam_pkg::UPD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         entry_data <= '0;
         entry_mask <= '0;
         entry_val  <= '0;
         entry_live <= '0;
      end else if (upd_done) begin
         if (cmd_op == tcam_pkg::OP_INIT) begin
            entry_live <= '0; // [RULE17]
         end else begin
            entry_data[cmd_idx] <= tcam_pkg::KEY_W'(stage_data); // [RULE17]
            entry_mask[cmd_idx] <= tcam_pkg::KEY_W'(stage_mask);
            entry_val[cmd_idx]  <= tcam_pkg::VAL_W'(stage_val);
            entry_live[cmd_idx] <= 1'b1;
         end
      end
   end

   // read channel
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign rd_go           = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_off          = s_axi_araddr_i[7:0];

   always_comb begin
      rd_mapped = 1'b1;
      rd_word   = '0;
      if (rd_off == tcam_pkg::OFF_ID) begin
         rd_word = tcam_pkg::DEVICE_ID; // [RULE10]
      end else if (rd_off == tcam_pkg::OFF_STATUS) begin
         rd_word[tcam_pkg::STAT_PEND] = (upd_state == tcam_pkg::UPD_PENDING);
         rd_word[tcam_pkg::STAT_BUSY] = (upd_state == tcam_pkg::UPD_BUSY);
      end else begin
         rd_mapped = 1'b0;
         for (int n = 0; n < tcam_pkg::KEY_WORDS; n++) begin
            if (rd_off == 8'(tcam_pkg::OFF_DATA + 4 * n)) begin
               rd_word   = stage_data[n]; // [RULE22]
               rd_mapped = 1'b1;
            end else if (rd_off == 8'(tcam_pkg::OFF_MASK + 4 * n)) begin
               rd_word   = stage_mask[n]; // [RULE22]
               rd_mapped = 1'b1;
            end
         end
         for (int n = 0; n < tcam_pkg::VAL_WORDS; n++) begin
            if (rd_off == 8'(tcam_pkg::OFF_VAL + 4 * n)) begin
               rd_word   = stage_val[n];
               rd_mapped = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= '0;
         s_axi_rresp_o  <= tcam_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= rd_word;
         s_axi_rresp_o  <= rd_mapped ? tcam_pkg::RESP_OKAY : tcam_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_strobe_error: assert property (wr_go && (s_axi_wstrb_i != tcam_pkg::STRB_FULL) // [RULE8]
      |=> s_axi_bvalid_o && (s_axi_bresp_o == tcam_pkg::RESP_SLVERR))
      else $error("partial strobe write not answered with slave error");
   a_id_write_err: assert property (wr_go && (wr_off == tcam_pkg::OFF_ID) // [RULE10]
      |=> s_axi_bresp_o == tcam_pkg::RESP_SLVERR)
      else $error("write to identifier not refused");
   a_id_readback: assert property (rd_go && (rd_off == tcam_pkg::OFF_ID) // [RULE10]
      |=> s_axi_rvalid_o && (s_axi_rdata_o == tcam_pkg::DEVICE_ID))
      else $error("identifier read returned wrong word");
   a_mask_load: assert property (wr_go && wr_ok && (wr_off == tcam_pkg::OFF_MASK) // [RULE14]
      |=> stage_mask[0] == $past(s_axi_wdata_i))
      else $error("mask staging word did not take the written data");
   a_no_dequeue: assert property ((upd_state == tcam_pkg::UPD_BUSY) |-> !pop) // [RULE19]
      else $error("request dequeued during update");
   a_update_span: assert property ($rose(upd_state == tcam_pkg::UPD_BUSY) // [RULE19]
      |-> ##32 upd_done ##1 (upd_state == tcam_pkg::UPD_IDLE))
      else $error("update hold not exactly 33 cycles");
   a_init_clears: assert property (upd_done && (cmd_op == tcam_pkg::OP_INIT) // [RULE17]
      |=> entry_live == '0)
      else $error("initialization left live entries");
   c_update_done: cover property (upd_done && (cmd_op == tcam_pkg::OP_WRITE));
   c_slverr: cover property (s_axi_bvalid_o && (s_axi_bresp_o == tcam_pkg::RESP_SLVERR));
   c_stalled_queue: cover property ((upd_state == tcam_pkg::UPD_BUSY) && push);
endmodule : tcam_lookup_engine

//--- search_requester.sv
// requester model standing in for the packet pipeline
`timescale 1ns/1ps
module search_requester (
   input  wire logic                       sys_clk_i,
   input  wire logic                       go_i,
   input  wire logic [tcam_pkg::KEY_W-1:0] key_i,
   output logic                            strobe_o,
   output logic [tcam_pkg::KEY_W-1:0]      key_o
);
   initial strobe_o = 1'b0;
   initial key_o = '0;
   // key valid in every strobe cycle; inverted between requests so stale keys never pass
   always @(posedge sys_clk_i) begin
      strobe_o <= go_i;
      key_o    <= go_i ? key_i : ~key_o;
   end
endmodule : search_requester

//--- test_ternary_match_lookup_engine.sv
// self-checking bench of the ternary lookup engine
`timescale 1ns/1ps
`define CHK(g,e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
`define WAITN(c) begin n = 0; while (!(c)) begin @(negedge clk); \
   if (++n > 80) begin err_total++; summarize(); end end end
module test_ternary_match_lookup_engine;
   logic        clk, rst_n, go, strobe, rs, hit;
   logic [63:0] key, skey, ekey;
   logic [3:0]  idx, wstrb;
   logic [31:0] val, awaddr, wdata, araddr, rdata;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   int          err_total, check_count, n;
   tcam_lookup_engine dut (
      .sys_clk_i(clk), .rst_n_i(rst_n), .search_request_strobe_i(strobe),
      .search_key_in_i(skey), .result_strobe_o(rs), .hit_flag_o(hit),
      .echoed_key_o(ekey), .winning_entry_index_o(idx), .winning_payload_o(val),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
   search_requester req (.sys_clk_i(clk), .go_i(go), .key_i(key), .strobe_o(strobe),
      .key_o(skey));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic summarize();
      if (err_total == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] e);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      `WAITN(awready && wready)
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      wdata   <= ~d;
      `WAITN(bvalid)
      `CHK(bresp, e)
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      `WAITN(arready)
      @(posedge clk);
      arvalid <= 1'b0;
      araddr  <= ~a;
      `WAITN(rvalid)
      d = rdata;
      r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [31:0] a, e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      `CHK(d, e)
      `CHK(r, er)
   endtask : rc
   // polls status, so the wait follows the update rather than a guessed count
   task automatic cmd(input logic [31:0] c);
      logic [31:0] d;
      logic [1:0]  r;
      wr(32'h10, c, 4'hf, 2'h0);
      d = 32'h3;
      for (int k = 0; k < 30 && d[1:0] != 2'h0; k++) rd(32'h14, d, r);
      `CHK(d[1:0], 2'h0)
   endtask : cmd
   task automatic load(input logic [3:0] i, input logic [63:0] d, m, input logic [31:0] v);
      wr(32'h50, d[31:0], 4'hf, 2'h0);
      wr(32'h54, d[63:32], 4'hf, 2'h0);
      wr(32'h90, m[31:0], 4'hf, 2'h0);
      wr(32'h94, m[63:32], 4'hf, 2'h0);
      wr(32'hd0, v, 4'hf, 2'h0);
      cmd({2'h1, 26'h0, i});
   endtask : load
   task automatic look(input logic [63:0] k, input logic h, input logic [3:0] i,
                       input logic [31:0] v);
      @(posedge clk);
      go  <= 1'b1;
      key <= k;
      @(posedge clk);
      go <= 1'b0;
      `WAITN(rs)
      `CHK(hit, h)
      `CHK(ekey, k)
      if (h) begin
         `CHK(idx, i)
         `CHK(val, v)
      end
      @(negedge clk);
      `CHK(rs, 1'b0)
   endtask : look
   initial begin
      {go, key, awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
      rst_n = 1'b0;
      repeat (12) @(posedge clk); // every stage here clears on one edge
      rst_n <= 1'b1;
      rc(32'h0, tcam_pkg::DEVICE_ID, 2'h0);
      wr(32'h0, 32'h1, 4'hf, 2'h2);
      wr(32'h50, 32'h1, 4'h3, 2'h2);
      rc(32'h50, 32'h0, 2'h0);
      rc(32'h58, 32'h0, 2'h2);
      wr(32'h4000_0094, 32'h5a5a_0f0f, 4'hf, 2'h0);
      rc(32'h94, 32'h5a5a_0f0f, 2'h0);
      look(64'h1, 1'b0, 4'h0, 32'h0);
      load(4'h5, 64'hcafe_0001_0000_0000, 64'h0000_0000_ffff_ffff, 32'ha5);
      load(4'h3, 64'hcafe_0001_0000_0010, 64'h0000_0000_ffff_0020, 32'ha3);
      rc(32'hd0, 32'ha3, 2'h0);
      look(64'hcafe_0001_0000_0015, 1'b1, 4'h3, 32'ha3);
      look(64'hcafe_0001_0000_0010, 1'b1, 4'h3, 32'ha3);
      look(64'hcafe_0001_0000_0020, 1'b1, 4'h3, 32'ha3);
      look(64'hcafe_0001_ffff_0021, 1'b1, 4'h5, 32'ha5);
      look(64'hcafe_0002_0000_0015, 1'b0, 4'h0, 32'h0);
      cmd({2'h2, 30'h0});
      look(64'hcafe_0001_0000_0015, 1'b0, 4'h0, 32'h0);
      summarize();
   end
endmodule : test_ternary_match_lookup_engine
